// >>> core/rcrs_sync.sv
// two-flop synchroniser for pin inputs
// assumes asynchronous inputs and one core clock
`timescale 1ns/1ps
module rcrs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q; // first stage, read only by second
  // two stages of capture
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// >>> core/rcrs_top.sv
// reset sequencing, reset-cause flags and return-stack pointer
// assumes rst is power-on reset; events are one-cycle pulses from core logic
// Functional notes
// - supply-settle timer always holds reset after power-up
// - crystal mode: count 1024 oscillator cycles first
// - code-start delay after power-on reset
// - non-power-on resets keep most register contents
// - power-on: flags set per power-on table
// - reset instruction clears software-reset flag only
// - brownout sets three flags, clears brownout flag
// - master-clear in run mode sets watchdog flag
// - master-clear idle/sleep: watchdog set, power-down clear
// - master-clear full power leaves flags unchanged
// - watchdog in run clears watchdog flag, resets
// - watchdog in idle/sleep wakes at PC+2
// - interrupt wake: PC+2 or vector, power-down cleared
// - pointer 0..31, pre-increment push, post-decrement pop
// - pointer resets to zero, software read/write
// - full flag after 31 pushes, software/power-on clear
// - error reset enabled: 31st push resets, pointer zero
// - error reset disabled: pointer saturates at 31
// - empty pop returns zero, sets underflow flag
// - underflow flag sticky until software or power-on
// - underflow with reset enable causes device reset
// - register layout: full b7, underflow b6, pointer b4:0
`timescale 1ns/1ps
module rcrs_top
  import rcrs_pkg::*;
#(
  parameter int SUPPLY_CYC = `RCRS_SUPPLY_SETTLE_CYC,
  parameter int CSD_CYC = `RCRS_CODE_START_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic osc_clk_tick,
  input wire logic crystal_mode,
  input wire logic external_reset_pin_n,
  input wire logic brownout_det,
  input wire logic watchdog_timeout,
  input wire logic reset_instr,
  input wire logic wake_interrupt,
  input wire rcrs_pkg::rcrs_pmode_type pmode,
  input wire logic high_priority_global_int_enable,
  input wire logic low_priority_global_int_enable,
  input wire logic int_high,
  input wire logic stack_error_reset_enable,
  input wire logic push_req,
  input wire logic pop_req,
  input wire logic [20:0] pc_cur,
  input wire logic sp_wr,
  input wire logic [7:0] sp_wdata,
  input wire logic reset_cause_register_wr,
  input wire logic [4:0] reset_cause_register_wdata,
  output logic core_reset,
  output logic pc_load,
  output logic [20:0] pc_load_val,
  output logic stack_wr,
  output logic [20:0] stack_wr_data,
  output logic [4:0] stack_wr_addr,
  output logic [4:0] reset_cause_register,
  output logic [7:0] return_stack_pointer_reg
);
  typedef struct packed {
    rcrs_seq_type seq;
    logic [16:0] cnt;
    logic [10:0] osc_cnt;
    logic software_reset_flag;
    logic watchdog_expiry_flag;
    logic power_down_flag;
    logic power_on_flag;
    logic brownout_flag;
    logic stack_full_flag;
    logic stack_underflow_flag;
    logic [4:0] stack_pointer_value;
    logic core_reset;
    logic pc_load;
    logic [20:0] pc_val;
    logic stack_wr;
    logic [20:0] stack_data;
    logic [4:0] stack_addr;
    logic external_reset_pin_prev;
    logic bor_prev;
  } rcrs_state_type;

  rcrs_state_type s_q, s_d;
  logic [2:0] pins_s; // synchronised pins
  logic external_reset_pin_n_s, bor_s, osc_s, osc_prev_q;
  logic osc_edge;

  // pin inputs pass two flops
  rcrs_sync #(.WIDTH(3)) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in({external_reset_pin_n, brownout_det, osc_clk_tick}),
    .sync_out(pins_s)
  );
  assign external_reset_pin_n_s = pins_s[2];
  assign bor_s = pins_s[1];
  assign osc_s = pins_s[0];

  // oscillator edge detect on synchronised level
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) osc_prev_q <= 1'b0;
    else osc_prev_q <= osc_s;
  end
  assign osc_edge = osc_s & ~osc_prev_q;

  // next-state logic
  always_comb begin
    logic external_reset_pin_fall, bor_rise, idle;
    logic [4:0] sp_inc;
    external_reset_pin_fall = 1'b0;
    bor_rise = 1'b0;
    idle = 1'b0;
    sp_inc = 5'h00;
    s_d = s_q;
    s_d.pc_load = 1'b0;
    s_d.stack_wr = 1'b0;
    s_d.external_reset_pin_prev = external_reset_pin_n_s;
    s_d.bor_prev = bor_s;
    external_reset_pin_fall = s_q.external_reset_pin_prev & ~external_reset_pin_n_s;
    bor_rise = bor_s & ~s_q.bor_prev;
    idle = (pmode == PM_IDLE) || (pmode == PM_SLEEP);
    sp_inc = s_q.stack_pointer_value + 5'h01;
    // power-up sequencer
    case (s_q.seq)
      ST_SUPPLY: begin
        s_d.core_reset = 1'b1;
        if (s_q.cnt >= 17'(SUPPLY_CYC - 1)) begin
          s_d.cnt = '0;
          s_d.seq = crystal_mode ? ST_OSC : ST_CSD;
        end else s_d.cnt = s_q.cnt + 17'h00001;
      end
      ST_OSC: begin
        if (osc_edge) begin
          if (s_q.osc_cnt == `RCRS_OSC_SETTLE_CYCLES - 11'h001) s_d.seq = ST_CSD;
          s_d.osc_cnt = s_q.osc_cnt + 11'h001;
        end
      end
      ST_CSD: begin
        if (s_q.cnt >= 17'(CSD_CYC - 1)) begin
          s_d.seq = ST_RUN;
          s_d.core_reset = 1'b0;
          s_d.pc_load = 1'b1;
          s_d.pc_val = `RCRS_RESET_VECTOR;
        end else s_d.cnt = s_q.cnt + 17'h00001;
      end
      ST_RUN: begin
        // event priority: brownout, master clear, watchdog, instruction
        if (bor_rise) begin
          s_d.software_reset_flag = 1'b1;
          s_d.watchdog_expiry_flag = 1'b1;
          s_d.power_down_flag = 1'b1;
          s_d.brownout_flag = 1'b0;
          s_d.pc_load = 1'b1;
          s_d.pc_val = `RCRS_RESET_VECTOR;
          s_d.stack_pointer_value = 5'h00;
        end else if (external_reset_pin_fall) begin
          if (pmode == PM_RUN) s_d.watchdog_expiry_flag = 1'b1;
          else if (idle) begin
            s_d.watchdog_expiry_flag = 1'b1;
            s_d.power_down_flag = 1'b0;
          end // full power keeps flags
          s_d.pc_load = 1'b1;
          s_d.pc_val = `RCRS_RESET_VECTOR;
          s_d.stack_pointer_value = 5'h00;
        end else if (watchdog_timeout) begin
          s_d.watchdog_expiry_flag = 1'b0;
          s_d.pc_load = 1'b1;
          if (idle) begin // wake, no reset, pointer kept
            s_d.power_down_flag = 1'b0;
            s_d.pc_val = pc_cur + `RCRS_PC_STEP;
          end else begin
            s_d.pc_val = `RCRS_RESET_VECTOR;
            s_d.stack_pointer_value = 5'h00;
          end
        end else if (reset_instr) begin
          s_d.software_reset_flag = 1'b0;
          s_d.pc_load = 1'b1;
          s_d.pc_val = `RCRS_RESET_VECTOR;
          s_d.stack_pointer_value = 5'h00;
        end else if (wake_interrupt && pmode != PM_FULL) begin
          s_d.power_down_flag = 1'b0;
          s_d.pc_load = 1'b1;
          if (high_priority_global_int_enable || low_priority_global_int_enable)
            s_d.pc_val = int_high ? `RCRS_HI_VECTOR : `RCRS_LO_VECTOR;
          else s_d.pc_val = pc_cur + `RCRS_PC_STEP;
        end else begin
          // software writes first; hardware sets below win
          if (sp_wr) begin
            s_d.stack_pointer_value = sp_wdata[4:0];
            if (!sp_wdata[`RCRS_SP_FULL_BIT]) s_d.stack_full_flag = 1'b0;
            if (!sp_wdata[`RCRS_SP_UNF_BIT]) s_d.stack_underflow_flag = 1'b0;
          end
          if (reset_cause_register_wr) begin
            s_d.software_reset_flag = reset_cause_register_wdata[4];
            s_d.watchdog_expiry_flag = reset_cause_register_wdata[3];
            s_d.power_down_flag = reset_cause_register_wdata[2];
            s_d.power_on_flag = reset_cause_register_wdata[1];
            s_d.brownout_flag = reset_cause_register_wdata[0];
          end
          if (push_req) begin // pre-increment push
            if (s_q.stack_pointer_value == `RCRS_SP_MAX) begin
              s_d.stack_full_flag = 1'b1; // saturate, no overwrite
              s_d.stack_pointer_value = `RCRS_SP_MAX;
            end else begin
              s_d.stack_wr = 1'b1;
              s_d.stack_addr = sp_inc;
              s_d.stack_data = pc_cur;
              s_d.stack_pointer_value = sp_inc;
              if (sp_inc == `RCRS_SP_MAX) begin
                s_d.stack_full_flag = 1'b1;
                if (stack_error_reset_enable) begin
                  s_d.stack_data = pc_cur + `RCRS_PC_STEP;
                  s_d.stack_pointer_value = 5'h00;
                  s_d.pc_load = 1'b1;
                  s_d.pc_val = `RCRS_RESET_VECTOR;
                end
              end
            end
          end else if (pop_req) begin
            s_d.pc_load = 1'b1;
            if (s_q.stack_pointer_value == 5'h00) begin
              s_d.stack_underflow_flag = 1'b1;
              s_d.pc_val = `RCRS_RESET_VECTOR;
              // with enable set this is a device reset
              if (stack_error_reset_enable) s_d.stack_pointer_value = 5'h00;
            end else begin // post-decrement pop
              s_d.pc_val = pc_cur;
              s_d.stack_pointer_value = s_q.stack_pointer_value - 5'h01;
            end
          end
        end
      end
      default: s_d.seq = ST_SUPPLY;
    endcase
    // registers beyond this block keep contents except on power-on
  end

  // state register; power-on values
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.seq <= ST_SUPPLY;
      s_q.core_reset <= 1'b1;
      s_q.software_reset_flag <= 1'b1;
      s_q.watchdog_expiry_flag <= 1'b1;
      s_q.power_down_flag <= 1'b1;
      s_q.pc_val <= `RCRS_RESET_VECTOR;
      s_q.external_reset_pin_prev <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops
  assign core_reset = s_q.core_reset;
  assign pc_load = s_q.pc_load;
  assign pc_load_val = s_q.pc_val;
  assign stack_wr = s_q.stack_wr;
  assign stack_wr_data = s_q.stack_data;
  assign stack_wr_addr = s_q.stack_addr;
  assign reset_cause_register = {s_q.software_reset_flag, s_q.watchdog_expiry_flag,
    s_q.power_down_flag, s_q.power_on_flag, s_q.brownout_flag};
  assign return_stack_pointer_reg = {s_q.stack_full_flag, s_q.stack_underflow_flag, 1'b0,
    s_q.stack_pointer_value};

  // assertions
  logic bor_rise_w, external_reset_pin_fall_w; // event copies for the checks below
  assign bor_rise_w = bor_s & ~s_q.bor_prev;
  assign external_reset_pin_fall_w = s_q.external_reset_pin_prev & ~external_reset_pin_n_s;
  // a push that lands on the top entry with no higher-priority event
  sequence push_to_top_s;
    push_req && !pop_req && s_q.seq == ST_RUN && s_q.stack_pointer_value == 5'h1e
      && !bor_rise_w && !external_reset_pin_fall_w && !watchdog_timeout && !reset_instr && !wake_interrupt;
  endsequence

  held_supply_a: assert property (@(posedge core_clk) disable iff (rst)
    s_q.seq == ST_SUPPLY |-> core_reset) else $error("reset released during supply settle");
  osc_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    s_q.seq == ST_OSC |-> core_reset && s_q.osc_cnt <= 11'h400)
    else $error("oscillator settle broken");
  csd_release_a: assert property (@(posedge core_clk) disable iff (rst)
    $fell(core_reset) |-> $past(s_q.seq) == ST_CSD) else $error("release skipped delay");
  full_reset_a: assert property (@(posedge core_clk) disable iff (rst)
    (push_to_top_s and stack_error_reset_enable) |=> return_stack_pointer_reg[7]
      && return_stack_pointer_reg[4:0] == 5'h00 && pc_load && pc_load_val == 21'h0)
    else $error("stack full reset wrong");
  full_sat_a: assert property (@(posedge core_clk) disable iff (rst)
    (push_to_top_s and !stack_error_reset_enable) |=> return_stack_pointer_reg[7]
      && return_stack_pointer_reg[4:0] == 5'h1f) else $error("stack full saturate wrong");
  unf_set_a: assert property (@(posedge core_clk) disable iff (rst)
    pc_load && $past(pop_req && !push_req) && $past(s_q.stack_pointer_value) == 5'h00
      && $past(s_q.seq) == ST_RUN && !$past(sp_wr)
      && !$past(bor_rise_w || external_reset_pin_fall_w || watchdog_timeout || reset_instr || wake_interrupt)
      |-> return_stack_pointer_reg[6])
    else $error("underflow flag not set");
  bit5_zero_a: assert property (@(posedge core_clk) disable iff (rst)
    !return_stack_pointer_reg[5]) else $error("unimplemented bit set");
  wdt_idle_a: assert property (@(posedge core_clk) disable iff (rst)
    s_q.seq == ST_RUN && watchdog_timeout && !bor_rise_w && !external_reset_pin_fall_w
      && (pmode == PM_IDLE || pmode == PM_SLEEP)
      |=> reset_cause_register[3:2] == 2'b00 && pc_load_val == $past(pc_cur) + 21'h2)
    else $error("watchdog wake wrong");
  rinstr_a: assert property (@(posedge core_clk) disable iff (rst)
    s_q.seq == ST_RUN && reset_instr && !bor_rise_w && !external_reset_pin_fall_w && !watchdog_timeout
      |=> !reset_cause_register[4] && $stable(reset_cause_register[3:0]))
    else $error("reset instruction flags wrong");
endmodule

// >>> inc/rcrs_pkg.sv
// types for the reset-cause and return-stack block
// assumes the constants header sits beside it
`include "rcrs_regs.svh"
package rcrs_pkg;
  // sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_SUPPLY = 4'h1,
    ST_OSC = 4'h2,
    ST_CSD = 4'h4,
    ST_RUN = 4'h8
  } rcrs_seq_type;
  // power mode of the core
  typedef enum logic [1:0] {
    PM_FULL = 2'h0,
    PM_RUN = 2'h1,
    PM_IDLE = 2'h2,
    PM_SLEEP = 2'h3
  } rcrs_pmode_type;
endpackage

// >>> inc/rcrs_regs.svh
// constants for the reset-cause and return-stack block
// assumes inclusion by the package only; definitions only
`ifndef RCRS_REGS_SVH
`define RCRS_REGS_SVH
`define RCRS_RESET_VECTOR 21'h000000
`define RCRS_HI_VECTOR 21'h000008
`define RCRS_LO_VECTOR 21'h000018
`define RCRS_PC_STEP 21'h000002
`define RCRS_OSC_SETTLE_CYCLES 11'h400
`define RCRS_SUPPLY_SETTLE_NS 65600
`define RCRS_CODE_START_NS 10000
`define RCRS_CLK_NS 100
`define RCRS_SUPPLY_SETTLE_CYC (`RCRS_SUPPLY_SETTLE_NS / `RCRS_CLK_NS)
`define RCRS_CODE_START_CYC ((`RCRS_CODE_START_NS + `RCRS_CLK_NS - 1) / `RCRS_CLK_NS)
`define RCRS_SP_FULL_BIT 7
`define RCRS_SP_UNF_BIT 6
`define RCRS_SP_MAX 5'h1f
`define RCRS_SPREG_RESET 8'h00
`endif

// >>> sim/rcrs_top_tb.sv
// self-checking bench for the reset-cause and return-stack block
// assumes the crystal model beside it; inputs change on rising edges
`timescale 1ns/1ps
module rcrs_top_tb;
  import rcrs_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic osc_en = 1'b1;
  logic external_reset_pin_hold = 1'b0;
  logic crystal_mode = 1'b1;
  logic brownout_det = 1'b0;
  logic stack_error_reset_enable = 1'b0;
  logic int_high = 1'b0;
  logic [1:0] gie = 2'h0;
  rcrs_pmode_type pmode = PM_FULL;
  logic [20:0] pc_cur = 21'h001234;
  logic [7:0] sp_wdata = 8'h00;
  logic [4:0] reset_cause_register_wdata = 5'h00;
  // one-cycle request pulses, one bit each
  logic [6:0] pls = 7'h00;
  wire push_req = pls[0];
  wire pop_req = pls[1];
  wire reset_instr = pls[2];
  wire watchdog_timeout = pls[3];
  wire wake_interrupt = pls[4];
  wire sp_wr = pls[5];
  wire reset_cause_register_wr = pls[6];
  logic osc_clk_tick, external_reset_pin_n, core_reset, pc_load, stack_wr;
  logic [20:0] pc_load_val, stack_wr_data;
  logic [4:0] stack_wr_addr, reset_cause_register;
  logic [7:0] return_stack_pointer_reg;
  wire [4:0] rcr = reset_cause_register;
  wire [7:0] rsp = return_stack_pointer_reg;
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc = 0;
  int n_load = 0;
  logic [20:0] last_pc = 21'h000000;
  rcrs_xtal_model xtal_u (.osc_en, .external_reset_pin_hold, .osc_clk_tick, .external_reset_pin_n);
  rcrs_top #(.SUPPLY_CYC(4), .CSD_CYC(2)) dut_u (
    .core_clk, .rst, .osc_clk_tick, .crystal_mode, .external_reset_pin_n, .brownout_det,
    .watchdog_timeout, .reset_instr, .wake_interrupt, .pmode,
    .high_priority_global_int_enable(gie[1]), .low_priority_global_int_enable(gie[0]),
    .int_high, .stack_error_reset_enable, .push_req, .pop_req, .pc_cur, .sp_wr,
    .sp_wdata, .reset_cause_register_wr, .reset_cause_register_wdata, .core_reset, .pc_load, .pc_load_val, .stack_wr,
    .stack_wr_data, .stack_wr_addr, .reset_cause_register, .return_stack_pointer_reg
  );
  always #50 core_clk = ~core_clk;
  // remembers every program-counter load, however short
  always @(posedge core_clk) begin
    if (pc_load === 1'b1) begin
      n_load <= n_load + 1;
      last_pc <= pc_load_val;
    end
  end
  // hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      bad("timeout");
      test_done();
    end
  end
  task automatic bad(string m);
    n_mismatch++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic cmp_bit(logic a, logic e);
    comparisons++;
    if (a !== e) bad($sformatf("bit %b want %b", a, e));
  endtask
  task automatic cmp_flags(logic [4:0] a, logic [4:0] e);
    comparisons++;
    if (a !== e) bad($sformatf("flags %h want %h", a, e));
  endtask
  task automatic cmp_sp(logic [7:0] a, logic [7:0] e);
    comparisons++;
    if (a !== e) bad($sformatf("stack %h want %h", a, e));
  endtask
  task automatic cmp_pc(logic [20:0] a, logic [20:0] e);
    comparisons++;
    if (a !== e) bad($sformatf("pc %h want %h", a, e));
  endtask
  task automatic test_done();
    $display("counts: %0d mismatches, %0d comparisons", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // raise request k for one cycle, return once its answer has landed
  task automatic pulse(int k);
    @(posedge core_clk) pls <= 7'h01 << k;
    @(posedge core_clk) pls <= 7'h00;
    #1;
  endtask
  task automatic wr_sp(logic [7:0] v);
    @(posedge core_clk) sp_wdata <= v;
    pulse(5);
  endtask
  // bounded wait for a pc load and for the core to leave reset
  task automatic wait_evt(int n0, logic [20:0] ep, logic [4:0] ef, output int n);
    n = 0;
    while (n_load == n0 && n < 6000) begin
      @(posedge core_clk) #1;
      n++;
    end
    cmp_bit(n_load != n0, 1'b1);
    cmp_pc(last_pc, ep);
    while (core_reset !== 1'b0 && n < 12000) begin
      @(posedge core_clk) #1;
      n++;
    end
    cmp_flags(rcr, ef);
  endtask
  // preset flags, raise event k in mode m (7 pin reset, 8 brownout)
  task automatic ev(int k, rcrs_pmode_type m, logic [4:0] f0, logic [20:0] ep, logic [4:0] ef);
    int n0;
    int n;
    @(posedge core_clk) pmode <= m;
    @(posedge core_clk) reset_cause_register_wdata <= f0;
    pulse(6);
    n0 = n_load;
    if (k >= 7) begin
      @(posedge core_clk) {external_reset_pin_hold, brownout_det} <= (k == 7) ? 2'b10 : 2'b01;
      repeat (4) @(posedge core_clk);
      {external_reset_pin_hold, brownout_det} <= 2'b00;
    end else begin
      pulse(k);
    end
    wait_evt(n0, ep, ef, n);
    repeat (4) @(posedge core_clk);
  endtask
  // n pushes from pointer base, each storing a fresh pc
  task automatic pushes(int n, int base);
    for (int i = 1; i <= n; i++) begin
      @(posedge core_clk) pc_cur <= 21'(i * 4);
      pulse(0);
      cmp_bit(stack_wr, 1'b1);
      cmp_sp({3'h0, stack_wr_addr}, 8'(base + i));
      cmp_pc(stack_wr_data, 21'(i * 4));
    end
  endtask
  initial begin
    int n;
    int n0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    cmp_bit(core_reset, 1'b1);
    cmp_flags(rcr, 5'h1c);
    cmp_sp(rsp, 8'h00);
    wait_evt(0, 21'h000000, 5'h1c, n);
    cmp_bit(n > 4000, 1'b1);
    @(posedge core_clk) crystal_mode <= 1'b0;
    $display("test power-up done");
    ev(2, PM_FULL, 5'h1f, 21'h000000, 5'h0f);
    ev(8, PM_FULL, 5'h03, 21'h000000, 5'h1e);
    ev(7, PM_RUN, 5'h00, 21'h000000, 5'h08);
    ev(7, PM_SLEEP, 5'h17, 21'h000000, 5'h1b);
    ev(7, PM_IDLE, 5'h04, 21'h000000, 5'h08);
    ev(7, PM_FULL, 5'h15, 21'h000000, 5'h15);
    ev(3, PM_RUN, 5'h1f, 21'h000000, 5'h17);
    ev(3, PM_FULL, 5'h0a, 21'h000000, 5'h02);
    ev(3, PM_IDLE, 5'h1f, 21'h001236, 5'h13);
    ev(3, PM_SLEEP, 5'h0e, 21'h001236, 5'h02);
    ev(4, PM_SLEEP, 5'h1f, 21'h001236, 5'h1b);
    @(posedge core_clk) {gie, int_high} <= 3'b101;
    ev(4, PM_IDLE, 5'h1f, 21'h000008, 5'h1b);
    @(posedge core_clk) {gie, int_high} <= 3'b010;
    ev(4, PM_IDLE, 5'h1f, 21'h000018, 5'h1b);
    @(posedge core_clk) pmode <= PM_FULL;
    $display("test reset causes done");
    pushes(31, 0);
    cmp_sp(rsp, 8'h9f);
    pulse(0);
    cmp_bit(stack_wr, 1'b0);
    cmp_sp(rsp, 8'h9f);
    pulse(1);
    cmp_pc(pc_load_val, 21'(31 * 4));
    cmp_sp(rsp, 8'h9e);
    wr_sp(8'h25);
    cmp_sp(rsp, 8'h05);
    wr_sp(8'h00);
    pulse(1);
    cmp_bit(pc_load, 1'b1);
    cmp_pc(pc_load_val, 21'h000000);
    cmp_sp(rsp, 8'h40);
    cmp_flags(rcr, 5'h1b);
    pushes(1, 0);
    pulse(1);
    cmp_sp(rsp, 8'h40);
    wr_sp(8'h00);
    cmp_sp(rsp, 8'h00);
    $display("test stack without reset done");
    @(posedge core_clk) stack_error_reset_enable <= 1'b1;
    pushes(30, 0);
    @(posedge core_clk) pc_cur <= 21'h000400;
    n0 = n_load;
    pulse(0);
    cmp_pc(stack_wr_data, 21'h000402);
    wait_evt(n0, 21'h000000, 5'h1b, n);
    cmp_sp(rsp, 8'h80);
    wr_sp(8'h00);
    n0 = n_load;
    pulse(1);
    wait_evt(n0, 21'h000000, 5'h1b, n);
    cmp_sp(rsp, 8'h40);
    $display("test stack with reset done");
    // second power-on without crystal settle: short path, flags back to power-on values
    @(posedge core_clk) rst <= 1'b1;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    n0 = n_load;
    wait_evt(n0, 21'h000000, 5'h1c, n);
    cmp_bit(n < 20, 1'b1);
    cmp_sp(rsp, 8'h00);
    $display("test warm power-on done");
    test_done();
  end
endmodule

// >>> sim/rcrs_xtal_model.sv
// crystal and master-clear button model facing the block
// assumes 1 ns units; the reset pin has a pull-up when released
`timescale 1ns/1ps
module rcrs_xtal_model #(
  parameter int HALF_NS = 200
) (
  input wire logic osc_en,
  input wire logic external_reset_pin_hold,
  output logic osc_clk_tick,
  output logic external_reset_pin_n
);
  // crystal runs free while powered, stands low otherwise
  initial osc_clk_tick = 1'b0;
  always #(HALF_NS) osc_clk_tick = osc_en & ~osc_clk_tick;
  // button pulls the pin low, pull-up lifts it when let go
  assign external_reset_pin_n = ~external_reset_pin_hold;
endmodule
